// ===== shared/wdg_pkg.sv
// constants and carrier types for the window watchdog and reset generator
// assumes a single 25 MHz system clock and strap levels static after reset
//
// Summary of operation
// - straps pick slow, fast or disabled watchdog
// - strap b low fast; a low b high slow
// - reset delay fast only when both straps low
// - hold reset low for delay after power-on
// - reset rising edge starts ignore window, trigger ignored
// - ignore end opens long window, four open windows
// - valid trigger in long window starts closed window
// - falling edge of trigger input is the event
// - valid: two high then two low samples
// - closed window expiry starts standard open window
// - valid trigger ends open window, new closed window
// - open window expiry without trigger asserts reset
// - trigger during closed window asserts reset
// - output undervoltage asserts reset
// - input undervoltage asserts reset on 3.3 V option
package wdg_pkg;
    localparam int CLK_HZ = 25000000;
    // sample tick period, in microseconds
    localparam int SAMPLE_US = 500;
    localparam int SAMPLE_CYC = CLK_HZ / 1000000 * SAMPLE_US;
    localparam logic [13:0] SAMPLE_LAST = 14'(SAMPLE_CYC - 1);
    // durations in milliseconds, fast timing
    localparam int RESET_DELAY_MS = 16;
    localparam int IGNORE_MS = 32;
    localparam int CLOSED_MS = 32;
    localparam int OPEN_MS = 32;
    localparam int LONG_OPEN_MS = 4 * OPEN_MS;
    localparam int TICKS_PER_MS = 1000 / SAMPLE_US;
    localparam logic [9:0] T_RESET = 10'(RESET_DELAY_MS * TICKS_PER_MS);
    localparam logic [9:0] T_IGNORE = 10'(IGNORE_MS * TICKS_PER_MS);
    localparam logic [9:0] T_CLOSED = 10'(CLOSED_MS * TICKS_PER_MS);
    localparam logic [9:0] T_OPEN = 10'(OPEN_MS * TICKS_PER_MS);
    localparam logic [9:0] T_LONG = 10'(LONG_OPEN_MS * TICKS_PER_MS);

    typedef enum logic [1:0] {WD_FAST, WD_SLOW, WD_OFF} wd_mode_t;

    typedef enum {
        ST_RESET, ST_IGNORE, ST_LONG, ST_CLOSED, ST_OPEN
    } wd_state_t;

    typedef struct packed {
        logic strap_a;
        logic strap_b;
    } straps_t;

    typedef struct packed {
        logic out_low;
        logic in_low;
    } supply_t;
endpackage

// ===== verilog/window_watchdog_reset_gen.sv
// window watchdog with power-on and undervoltage reset generation
// assumes trigger, straps and comparator levels are synchronous to sys_clk
`timescale 1ns/100ps
module window_watchdog_reset_gen
    import wdg_pkg::*;
#(
    parameter bit LOW_VOLT_OPTION = 1'b0,
    // clocks per sample tick; every window scales with it alike
    parameter int SAMPLE_DIV = SAMPLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire straps_t straps,
    input wire supply_t supply,
    input wire logic watchdog_trigger_in,
    output logic cpu_reset_out_b,
    output logic cpu_reset_oe_b,
    output wd_state_t window_state
);

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    function automatic wd_mode_t wd_mode(input straps_t s);
        if (!s.strap_b) begin
            return WD_FAST;
        end else if (!s.strap_a) begin
            return WD_SLOW;
        end
        return WD_OFF;
    endfunction

    function automatic logic reset_slow(input straps_t s);
        return s.strap_a | s.strap_b;
    endfunction

    // a duration scaled for slow mode; widths hold the doubled long window
    function automatic logic [10:0] scaled(input logic [9:0] t,
                                           input logic slow);
        return slow ? {t, 1'b0} : {1'b0, t};
    endfunction

    typedef struct packed {
        wd_state_t st;
        logic [13:0] div;
        logic tick;
        logic [10:0] cnt;
        logic [3:0] hist;
        logic rst_out;
    } state_t;

    state_t s_q, s_d;
    wd_mode_t mode;
    logic uv;
    logic valid_trig;
    logic wd_slow;
    // last divider count of one sample period
    localparam logic [13:0] DIV_LAST = 14'(SAMPLE_DIV - 1);

    assign mode = wd_mode(straps);
    assign wd_slow = (mode == WD_SLOW);
    assign uv = supply.out_low | (LOW_VOLT_OPTION & supply.in_low);
    // two high then two low samples on the sample tick
    assign valid_trig = s_q.tick && (s_q.hist == 4'b1100);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.div == DIV_LAST) begin
            s_d.div = 14'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 14'h0001;
        end
        if (s_q.tick) begin
            s_d.hist = {s_q.hist[2:0], watchdog_trigger_in};
            s_d.cnt = s_q.cnt + 11'h001;
        end
        if (uv) begin
            s_d.st = ST_RESET;
            s_d.cnt = 11'h000;
            s_d.rst_out = 1'b0;
        end else begin
            unique case (s_q.st)
                ST_RESET: begin
                    // reset delay counts only while the supply is good
                    if (s_q.cnt >= scaled(T_RESET, reset_slow(straps))) begin
                        s_d.rst_out = 1'b1;
                        s_d.st = ST_IGNORE;
                        s_d.cnt = 11'h000;
                    end
                end
                ST_IGNORE: begin
                    // trigger history keeps shifting, but is not acted on
                    if (s_q.cnt >= scaled(T_IGNORE, wd_slow)) begin
                        s_d.st = ST_LONG;
                        s_d.cnt = 11'h000;
                    end
                end
                ST_LONG: begin
                    if (valid_trig) begin
                        s_d.st = ST_CLOSED;
                        s_d.cnt = 11'h000;
                    end else if (s_q.cnt >= scaled(T_LONG, wd_slow)) begin
                        s_d.st = ST_RESET;
                        s_d.rst_out = 1'b0;
                        s_d.cnt = 11'h000;
                    end
                end
                ST_CLOSED: begin
                    if (valid_trig) begin
                        s_d.st = ST_RESET;
                        s_d.rst_out = 1'b0;
                        s_d.cnt = 11'h000;
                    end else if (s_q.cnt >= scaled(T_CLOSED, wd_slow)) begin
                        s_d.st = ST_OPEN;
                        s_d.cnt = 11'h000;
                    end
                end
                ST_OPEN: begin
                    if (valid_trig) begin
                        s_d.st = ST_CLOSED;
                        s_d.cnt = 11'h000;
                    end else if (s_q.cnt >= scaled(T_OPEN, wd_slow)) begin
                        s_d.st = ST_RESET;
                        s_d.rst_out = 1'b0;
                        s_d.cnt = 11'h000;
                    end
                end
            endcase
            // disabled watchdog parks in the ignore window
            if (mode == WD_OFF && s_q.st != ST_RESET) begin
                s_d.st = ST_IGNORE;
                s_d.cnt = 11'h000;
                s_d.rst_out = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: ST_RESET, div: 14'h0000, tick: 1'b0,
                     cnt: 11'h000, hist: 4'h0, rst_out: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // open-drain reset: enable low while pulling the pin low
    assign cpu_reset_out_b = 1'b0;
    assign cpu_reset_oe_b = s_q.rst_out;
    assign window_state = s_q.st;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    uv_reset_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        supply.out_low |=> !s_q.rst_out)
        else $error("reset not asserted on undervoltage");

    in_low_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (LOW_VOLT_OPTION && supply.in_low) |=> !s_q.rst_out)
        else $error("reset not asserted on input undervoltage");

    closed_early_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (s_q.st == ST_CLOSED && valid_trig && !uv && mode != WD_OFF)
        |=> s_q.st == ST_RESET && !s_q.rst_out)
        else $error("early trigger did not reset");

    open_trig_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (s_q.st == ST_OPEN && valid_trig && !uv && mode != WD_OFF)
        |=> s_q.st == ST_CLOSED && s_q.cnt == 11'h000)
        else $error("open window trigger not taken");

    long_trig_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (s_q.st == ST_LONG && valid_trig && !uv && mode != WD_OFF)
        |=> s_q.st == ST_CLOSED)
        else $error("long window trigger not taken");

    long_expire_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (s_q.st == ST_LONG && !valid_trig && !uv && mode != WD_OFF
         && s_q.cnt >= scaled(T_LONG, wd_slow))
        |=> s_q.st == ST_RESET && !s_q.rst_out)
        else $error("long window expiry did not reset");

    release_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        $rose(s_q.rst_out) |-> s_q.st == ST_IGNORE && s_q.cnt == 11'h000)
        else $error("reset release did not start ignore window");

    delay_done_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        $rose(s_q.rst_out)
        |-> $past(s_q.cnt) >= scaled(T_RESET, reset_slow(straps)))
        else $error("reset released before the delay");

    ignore_hold_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (s_q.st == ST_IGNORE && valid_trig && !uv
         && s_q.cnt < 11'(T_IGNORE)) |=> s_q.st == ST_IGNORE)
        else $error("trigger acted on in ignore window");

    off_mode_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (mode == WD_OFF && !uv && s_q.rst_out) |=> s_q.rst_out)
        else $error("disabled watchdog asserted reset");

    open_expire_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (s_q.st == ST_OPEN && !valid_trig && !uv && mode == WD_FAST
         && s_q.cnt == 11'(T_OPEN)) |=> !s_q.rst_out)
        else $error("open window expiry did not reset");

    // only meaningful while a sample period is longer than eight clocks
    tick_rate_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        s_q.tick |=> !s_q.tick [*8])
        else $error("sample tick too frequent");
endmodule

// ===== sim/trigger_cpu.sv
// processor model: drives the watchdog trigger line, idle low
// assumes the watchdog samples the line once every TICK clocks
`timescale 1ns/100ps
module trigger_cpu
    import wdg_pkg::*;
#(
    parameter int TICK = SAMPLE_CYC
) (
    input wire logic sys_clk,
    output logic watchdog_trigger_in
);
    // fast timing aim: closed window plus half an open window, in ticks
    localparam int PERIOD = int'(T_CLOSED) + int'(T_OPEN) / 2;

    initial watchdog_trigger_in = 1'b0;

    // three ticks on each level so two samples land on either side
    task automatic pulse();
        @(negedge sys_clk);
        watchdog_trigger_in = 1'b1;
        repeat (3 * TICK) @(negedge sys_clk);
        watchdog_trigger_in = 1'b0;
        repeat (3 * TICK) @(negedge sys_clk);
    endtask

    // steady pulses, one period from start to start; pulse takes 6 ticks
    task automatic serve(input int n);
        repeat (n) begin
            repeat ((PERIOD - 6) * TICK - 1) @(negedge sys_clk);
            pulse();
        end
    endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the window watchdog and reset generator
// assumes the processor model trigger_cpu and counts fixed in ticks
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end end
module testbench
    import wdg_pkg::*;
;
    // short sample period keeps the run brief; durations are in ticks
    localparam int TICK = 16;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    straps_t straps = 2'h0;
    supply_t supply = 2'h0;
    logic watchdog_trigger_in;
    logic cpu_reset_out_b;
    logic cpu_reset_oe_b;
    logic lv_oe_b;
    wd_state_t window_state;
    int mismatches = 0;
    int checks = 0;
    int t;
    typedef struct { straps_t s; int rst_t; int ign_t; } row_t;
    // ign_t of zero marks the disabled mode
    row_t rows[4] = '{'{2'h0, 32, 64}, '{2'h1, 64, 128},
                      '{2'h2, 64, 64}, '{2'h3, 64, 0}};

    always #20 sys_clk = ~sys_clk;

    window_watchdog_reset_gen #(.SAMPLE_DIV(TICK)) DUT (.sys_clk(sys_clk),
        .rst_b(rst_b), .straps(straps), .supply(supply),
        .watchdog_trigger_in(watchdog_trigger_in),
        .cpu_reset_out_b(cpu_reset_out_b),
        .cpu_reset_oe_b(cpu_reset_oe_b), .window_state(window_state));
    // second copy with the input comparator option turned on
    window_watchdog_reset_gen #(.LOW_VOLT_OPTION(1'b1), .SAMPLE_DIV(TICK))
        DUT_lv (.sys_clk(sys_clk), .rst_b(rst_b), .straps(straps),
        .supply(supply), .watchdog_trigger_in(watchdog_trigger_in),
        .cpu_reset_out_b(), .cpu_reset_oe_b(lv_oe_b), .window_state());
    trigger_cpu #(.TICK(TICK)) cpu (.sys_clk(sys_clk),
        .watchdog_trigger_in(watchdog_trigger_in));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ticks spent in st; the bound cuts a hang short
    task automatic stay(input wd_state_t st, input int lim);
        int n;
        n = 0;
        while (window_state === st) begin
            @(negedge sys_clk);
            n++;
            if (n > lim * TICK) begin
                mismatches++;
                $display("wrong value timeout exp %0d got %0d", lim, n);
                give_verdict();
            end
        end
        t = (n + TICK / 2) / TICK;
    endtask

    // tick phase and detection lag blur a duration by a few ticks
    function automatic int near(input int e);
        return (t >= e - 4 && t <= e + 2) ? e : t;
    endfunction

    task automatic do_reset(input straps_t s);
        straps = s;
        rst_b = 1'b0;
        repeat (16) @(negedge sys_clk);
        `CHK("oe_b in reset", 1'b0, cpu_reset_oe_b)
        `CHK("state in reset", ST_RESET, window_state)
        `CHK("pin value", 1'b0, cpu_reset_out_b)
        rst_b = 1'b1;
        stay(ST_RESET, 80);
    endtask

    initial begin
        // ----------------------------------------
        // strap table
        // ----------------------------------------
        foreach (rows[i]) begin
            do_reset(rows[i].s);
            `CHK("reset ticks", rows[i].rst_t, near(rows[i].rst_t))
            `CHK("oe_b released", 1'b1, cpu_reset_oe_b)
            if (rows[i].ign_t > 0) begin
                stay(ST_IGNORE, 140);
                `CHK("ignore ticks", rows[i].ign_t, near(rows[i].ign_t))
                `CHK("after ignore", ST_LONG, window_state)
            end else begin
                cpu.pulse();
                repeat (70 * TICK) @(negedge sys_clk);
                `CHK("parked", ST_IGNORE, window_state)
                `CHK("off oe_b", 1'b1, cpu_reset_oe_b)
            end
            $display("test straps %0h done", rows[i].s);
        end
        // ----------------------------------------
        // window sequence, fast timing
        // ----------------------------------------
        do_reset(2'h0);
        cpu.pulse();
        `CHK("trigger ignored", ST_IGNORE, window_state)
        stay(ST_IGNORE, 70);
        cpu.pulse();
        `CHK("long then closed", ST_CLOSED, window_state)
        stay(ST_CLOSED, 70);
        `CHK("closed ticks", 64, near(64))
        `CHK("closed then open", ST_OPEN, window_state)
        cpu.pulse();
        `CHK("open then closed", ST_CLOSED, window_state)
        stay(ST_CLOSED, 70);
        stay(ST_OPEN, 70);
        `CHK("open ticks", 64, near(64))
        `CHK("missed trigger", ST_RESET, window_state)
        `CHK("missed oe_b", 1'b0, cpu_reset_oe_b)
        $display("test window cycle done");
        stay(ST_RESET, 80);
        stay(ST_IGNORE, 70);
        cpu.pulse();
        cpu.pulse();
        `CHK("early trigger", ST_RESET, window_state)
        `CHK("early oe_b", 1'b0, cpu_reset_oe_b)
        stay(ST_RESET, 80);
        stay(ST_IGNORE, 70);
        stay(ST_LONG, 270);
        `CHK("long ticks", 256, near(256))
        `CHK("long expiry", ST_RESET, window_state)
        stay(ST_RESET, 80);
        `CHK("restart", ST_IGNORE, window_state)
        $display("test early and missing triggers done");
        // steady triggering at the aimed period keeps reset released
        stay(ST_IGNORE, 70);
        cpu.pulse();
        cpu.serve(3);
        `CHK("served state", ST_CLOSED, window_state)
        `CHK("served oe_b", 1'b1, cpu_reset_oe_b)
        $display("test steady trigger done");
        // input comparator alone, option off and on; then the output comparator
        supply = 2'h1;
        repeat (8) @(negedge sys_clk);
        `CHK("in_low ignored", 1'b1, cpu_reset_oe_b)
        `CHK("in_low option", 1'b0, lv_oe_b)
        supply = 2'h2;
        repeat (8) @(negedge sys_clk);
        `CHK("undervoltage", 1'b0, cpu_reset_oe_b)
        supply = 2'h0;
        stay(ST_RESET, 80);
        `CHK("recovered", 1'b1, cpu_reset_oe_b)
        `CHK("option recovered", 1'b1, lv_oe_b)
        $display("test undervoltage done");
        give_verdict();
    end
endmodule
